// *** core/dpr_block_ram.sv ***
// Dual-port block memory with variable aspect ratios, split and
// split read/write modes, SECDED, and a built-in queue controller.
// Assumes both ports and the register port are synchronous to clk.
`timescale 1ns/10ps

module dpr_block_ram
  import dpr_pkg::*;
#(
  parameter int CASCADE = 0  // 1 joins two adjacent blocks
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                resetn,
  // Port A
  input  wire logic                a_en,
  input  wire logic [LANES-1:0]    a_we,
  input  wire logic [ADDR_W-1:0]   a_addr,
  input  wire logic [WORD_W-1:0]   a_din,
  output logic      [WORD_W-1:0]   a_dout,
  // Port B
  input  wire logic                b_en,
  input  wire logic [LANES-1:0]    b_we,
  input  wire logic [ADDR_W-1:0]   b_addr,
  input  wire logic [WORD_W-1:0]   b_din,
  output logic      [WORD_W-1:0]   b_dout,
  // Queue handshake (data on a_din and b_dout)
  input  wire logic                fifo_wr,
  input  wire logic                fifo_rd,
  output logic                     fifo_full,
  output logic                     fifo_empty,
  output logic                     fifo_afull,
  output logic                     fifo_aempty,
  // Error status of port B reads
  output logic                     ecc_single,
  output logic                     ecc_double,
  // Standalone codec for external memories
  input  wire logic [63:0]         ext_data,
  output logic      [7:0]          ext_check,
  input  wire logic [WORD_W-1:0]   ext_code,
  output logic      [63:0]         ext_fixed,
  output logic                     ext_single,
  output logic                     ext_double,
  // Register port
  input  wire logic [4:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [31:0]         reg_rdata
);

  localparam int WORDS = BASE_WORDS << CASCADE;  // Words of 72 bits
  localparam int WIX   = $clog2(WORDS);          // Word index width

  // Only one or two cascaded blocks can be built
  if (CASCADE < 0 || CASCADE > 1) begin : g_bad_param
    $error("CASCADE must be 0 or 1");
  end

  // Width in bits of a width code
  function automatic int unsigned wbits(input logic [2:0] c);
    case (c)
      3'h0:    return 1;
      3'h1:    return 2;
      3'h2:    return 4;
      3'h3:    return 9;
      3'h4:    return 18;
      3'h5:    return 36;
      default: return 72;
    endcase
  endfunction

  // Narrow widths skip parity bits: data bit i sits in lane i/8
  function automatic logic [71:0] merge(input logic [71:0] old, input logic [71:0] din,
                                        input logic [2:0] c, input logic [5:0] k, input logic [7:0] be);
    logic [71:0] r;
    int unsigned w;
    int unsigned base;
    r    = old;
    w    = wbits(c);
    base = k * w;
    for (int i = 0; i < 72; i++) begin
      if (c < WC_9) begin
        if (i < 64 && i >= base && i < base + w) r[(i / 8) * 9 + i % 8] = din[i - base];
      end else if (i >= base && i < base + w && be[(i - base) / 9]) begin
        r[i] = din[i - base];
      end
    end
    return r;
  endfunction

  // Pick one element of a stored word
  function automatic logic [71:0] pick(input logic [71:0] word, input logic [2:0] c, input logic [5:0] k);
    logic [71:0] src;
    logic [71:0] msk;
    int unsigned w;
    w   = wbits(c);
    src = word;
    if (c < WC_9) begin
      src = '0;
      for (int i = 0; i < 64; i++) src[i] = word[(i / 8) * 9 + i % 8];
    end
    msk = (c == WC_72) ? '1 : ((72'h1 << w) - 72'h1);
    return (src >> (k * w)) & msk;
  endfunction

  // Stored layout of a protected word: data bytes, check bits as parity
  function automatic logic [71:0] pack(input logic [63:0] d, input logic [7:0] chk);
    logic [71:0] r;
    for (int j = 0; j < 8; j++) r[j * 9 +: 9] = {chk[j], d[j * 8 +: 8]};
    return r;
  endfunction

  // Storage array, no reset on contents
  logic [WORD_W-1:0] mem [WORDS];

  // Configuration registers
  logic [CTRL_W-1:0]  ctrl_r;    // Modes and per-port options
  logic [WIDTH_W-1:0] width_r;   // Width codes of both ports
  logic [CNT_W-1:0]   afull_r;   // Almost-full level
  logic [CNT_W-1:0]   aempty_r;  // Almost-empty level

  // Decoded modes
  wire logic split   = ctrl_r[CB_SPLIT];
  wire logic srw     = ctrl_r[CB_SRW];
  wire logic fifo_on = ctrl_r[CB_FIFO];
  wire logic fwft    = ctrl_r[CB_FWFT];
  wire logic ecc_on  = ctrl_r[CB_ECC];
  wire logic ctrl_wr = reg_wr && reg_addr == OFF_CTRL;
  wire logic [2:0] wc_a = width_r[WB_A +: 3];
  wire logic [2:0] wc_b = fifo_on ? wc_a : width_r[WB_B +: 3];

  // Legal widths: split halves stop at 18 bits, full at 36, unless split read/write or queue mode
  wire logic [2:0] max_tdp  = split ? WC_18 : WC_36;
  wire logic       fixed_ok = split ? (wc_a == WC_36 || wc_b == WC_36) : (wc_a >= WC_36 || wc_b >= WC_36);
  wire logic       cfg_bad  = wc_a == WC_BAD || wc_b == WC_BAD
                           || (split && (wc_a == WC_72 || wc_b == WC_72))
                           || (srw && !fifo_on && !fixed_ok)
                           || (!srw && !fifo_on && (wc_a > max_tdp || wc_b > max_tdp));

  // Queue pointers count elements and wrap freely
  logic [CNT_W-1:0] wptr_r;
  logic [CNT_W-1:0] rptr_r;
  logic             fv_r;       // Fall-through word is on b_dout
  wire logic [2:0]       sh_a    = 3'h6 - wc_a;
  wire logic [CNT_W-1:0] depth   = (split ? 17'(HALF_WORDS) : 17'(WORDS)) << sh_a;
  wire logic [CNT_W-1:0] count   = wptr_r - rptr_r;
  wire logic             full_i  = count == depth;
  wire logic             empty_i = count == 17'h00000;
  wire logic             wr_ok   = fifo_on && !cfg_bad && fifo_wr && !full_i;
  wire logic             rd_go   = fifo_on && !cfg_bad && !empty_i &&
                                   (fwft ? (!fv_r || fifo_rd) : fifo_rd);
  wire logic [CNT_W-1:0] wptr_nxt  = wptr_r + 17'(wr_ok);
  wire logic [CNT_W-1:0] rptr_nxt  = rptr_r + 17'(rd_go);
  wire logic [CNT_W-1:0] count_nxt = wptr_nxt - rptr_nxt;
  // Fall-through word stays until read; a read with none shown is dropped
  wire logic             fv_nxt    = rd_go ? 1'b1 : (fifo_rd ? 1'b0 : fv_r);

  // Effective per-port requests
  logic [2:0]        p_wc   [2];
  logic              p_go   [2];
  logic [LANES-1:0]  p_we   [2];
  logic [ADDR_W-1:0] p_addr [2];
  logic [WORD_W-1:0] p_din  [2];
  logic              p_half [2];
  logic              p_rdok [2];
  logic              p_oreg [2];
  logic [1:0]        p_wm   [2];
  logic [WORD_W-1:0] p_lat  [2];
  logic [WORD_W-1:0] p_new  [2];
  logic              p_wgo  [2];
  logic [WIX-1:0]    p_widx [2];
  logic [WORD_W-1:0] p_old  [2];

  assign p_wc[0]   = wc_a;
  assign p_wc[1]   = wc_b;
  assign p_go[0]   = fifo_on ? wr_ok : a_en && !cfg_bad;
  assign p_go[1]   = fifo_on ? rd_go : b_en && !cfg_bad;
  assign p_we[0]   = fifo_on ? 8'hff : a_we;
  assign p_we[1]   = (fifo_on || srw) ? 8'h00 : b_we;
  assign p_addr[0] = fifo_on ? wptr_r[ADDR_W-1:0] : a_addr;
  assign p_addr[1] = fifo_on ? rptr_r[ADDR_W-1:0] : b_addr;
  assign p_din[0]  = a_din;
  assign p_din[1]  = b_din;
  assign p_half[0] = ctrl_r[CB_A_HALF];
  assign p_half[1] = fifo_on ? ctrl_r[CB_A_HALF] : ctrl_r[CB_B_HALF];
  assign p_rdok[0] = !srw && !fifo_on;
  assign p_rdok[1] = 1'b1;
  assign p_oreg[0] = ctrl_r[CB_A_OREG];
  assign p_oreg[1] = ctrl_r[CB_B_OREG] && !fifo_on;
  assign p_wm[0]   = ctrl_r[CB_A_WM +: 2];
  assign p_wm[1]   = ctrl_r[CB_B_WM +: 2];

  // Codec on the memory path: encode port A writes, decode port B reads
  dpr_ecc_if mem_ecc ();
  dpr_ecc    u_mem_ecc (.e(mem_ecc));
  assign mem_ecc.enc_data = a_din[63:0];
  always_comb begin
    for (int j = 0; j < 8; j++) begin
      mem_ecc.dec_data[j * 8 +: 8] = p_old[1][j * 9 +: 8];
      mem_ecc.dec_check[j]         = p_old[1][j * 9 + 8];
    end
  end
  wire logic ecc_wr = ecc_on && wc_a == WC_72;   // Whole protected words only
  wire logic ecc_rd = ecc_on && wc_b == WC_72;

  // Per-port address decode, write merge and read latch
  for (genvar g = 0; g < 2; g++) begin : g_port
    logic [WORD_W-1:0] lat_r;   // Latched read element
    logic [WORD_W-1:0] dout_r;  // Port output register
    logic [WORD_W-1:0] lat_nxt;
    logic [WORD_W-1:0] view;
    wire logic [2:0]        sh    = 3'h6 - p_wc[g];
    wire logic [ADDR_W-1:0] wsel  = p_addr[g] >> sh;
    wire logic [5:0]        k     = p_addr[g][5:0] & ((6'h01 << sh) - 6'h01);
    wire logic              wr    = p_go[g] && |p_we[g];
    wire logic              rd    = p_go[g] && (wr || p_rdok[g]);

    // Split mode confines each port to its chosen half
    assign p_widx[g] = split ? WIX'({p_half[g], wsel[7:0]}) : wsel[WIX-1:0];
    assign p_old[g]  = mem[p_widx[g]];
    assign p_wgo[g]  = wr;
    assign p_new[g]  = (g == 0 && ecc_wr) ? pack(a_din[63:0], mem_ecc.enc_check)
                                          : merge(p_old[g], p_din[g], p_wc[g], k, p_we[g]);
    // Port B in protected mode returns corrected data and stored checks
    assign view = (g == 1 && ecc_rd) ? {mem_ecc.dec_check, mem_ecc.dec_fixed} : pick(p_old[g], p_wc[g], k);

    // Read-during-write policy; no access keeps the old element
    always_comb begin
      lat_nxt = lat_r;
      if (rd && !wr) lat_nxt = view;
      else if (rd) begin
        case (p_wm[g])
          WM_WRITE_FIRST: lat_nxt = pick(p_new[g], p_wc[g], k);
          WM_NO_CHANGE:   lat_nxt = lat_r;
          default:        lat_nxt = view;
        endcase
      end
    end

    // Latch then optional pipeline stage
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        lat_r  <= '0;
        dout_r <= '0;
      end else begin
        lat_r  <= lat_nxt;
        dout_r <= p_oreg[g] ? lat_r : lat_nxt;
      end
    end
    assign p_lat[g] = lat_r;
  end

  assign a_dout = g_port[0].dout_r;
  assign b_dout = g_port[1].dout_r;

  // Array writes, port B last on a same-word collision
  always_ff @(posedge clk) begin
    for (int p = 0; p < 2; p++) begin
      if (p_wgo[p]) mem[p_widx[p]] <= p_new[p];
    end
  end

  // Configuration writes; a control write also empties the queue
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r   <= CTRL_RST;
      width_r  <= WIDTH_RST;
      afull_r  <= AFULL_RST;
      aempty_r <= AEMPTY_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        OFF_CTRL:   ctrl_r   <= reg_wdata[CTRL_W-1:0];
        OFF_WIDTH:  width_r  <= reg_wdata[WIDTH_W-1:0];
        OFF_AFULL:  afull_r  <= reg_wdata[CNT_W-1:0];
        OFF_AEMPTY: aempty_r <= reg_wdata[CNT_W-1:0];
        default:    ;                                           // Unmapped writes dropped
      endcase
    end
  end

  // Queue pointers and registered flags
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wptr_r      <= '0;
      rptr_r      <= '0;
      fv_r        <= 1'b0;
      fifo_full   <= 1'b0;
      fifo_empty  <= 1'b1;
      fifo_afull  <= 1'b0;
      fifo_aempty <= 1'b1;
    end else if (ctrl_wr) begin
      wptr_r      <= '0;
      rptr_r      <= '0;
      fv_r        <= 1'b0;
      fifo_full   <= 1'b0;
      fifo_empty  <= 1'b1;
      fifo_afull  <= 1'b0;
      fifo_aempty <= 1'b1;
    end else begin
      wptr_r      <= wptr_nxt;
      rptr_r      <= rptr_nxt;
      fv_r        <= fwft && fv_nxt;
      fifo_full   <= count_nxt == depth;
      fifo_empty  <= fwft ? !fv_nxt : count_nxt == 17'h00000;
      fifo_afull  <= count_nxt >= afull_r;
      fifo_aempty <= count_nxt <= aempty_r;
    end
  end

  // Error status of the latest protected port B read
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ecc_single <= 1'b0;
      ecc_double <= 1'b0;
    end else if (p_go[1] && ecc_rd) begin
      ecc_single <= mem_ecc.dec_single;
      ecc_double <= mem_ecc.dec_double;
    end
  end

  // Standalone codec, results registered
  dpr_ecc_if x_ecc ();
  dpr_ecc    u_ext_ecc (.e(x_ecc));
  assign x_ecc.enc_data  = ext_data;
  assign x_ecc.dec_data  = ext_code[63:0];
  assign x_ecc.dec_check = ext_code[71:64];
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ext_check  <= '0;
      ext_fixed  <= '0;
      ext_single <= 1'b0;
      ext_double <= 1'b0;
    end else begin
      ext_check  <= x_ecc.enc_check;
      ext_fixed  <= x_ecc.dec_fixed;
      ext_single <= x_ecc.dec_single;
      ext_double <= x_ecc.dec_double;
    end
  end

  // Register read mux, data valid only in the cycle after the strobe
  logic [31:0] rd_mux;
  always_comb begin
    case (reg_addr)
      OFF_CTRL:   rd_mux = 32'(ctrl_r);
      OFF_WIDTH:  rd_mux = 32'(width_r);
      OFF_AFULL:  rd_mux = 32'(afull_r);
      OFF_AEMPTY: rd_mux = 32'(aempty_r);
      OFF_STATUS: rd_mux = {25'h0000000, ecc_double, ecc_single, cfg_bad,
                            fifo_aempty, fifo_afull, fifo_empty, fifo_full};
      OFF_COUNT:  rd_mux = 32'(count);
      default:    rd_mux = 32'h00000000;
    endcase
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) reg_rdata <= '0;
    else         reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
  end

  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  full_block_a:
    assert property (fifo_on && full_i && fifo_wr && !ctrl_wr |=> wptr_r == $past(wptr_r)) else $error("write taken while full");
  empty_block_a:
    assert property (fifo_on && empty_i && fifo_rd && !ctrl_wr |=> $stable(rptr_r)) else $error("read taken while empty");
  oreg_delay_a:
    assert property ($past(p_oreg[0]) |-> a_dout == $past(p_lat[0])) else $error("output stage latency wrong");
  direct_out_a:
    assert property ($past(!p_oreg[1]) |-> b_dout == p_lat[1]) else $error("direct output mismatch");
  hold_data_a:
    assert property (!p_go[0] |=> $stable(p_lat[0])) else $error("read data moved without access");
  no_change_a:
    assert property (p_go[0] && |p_we[0] && p_wm[0] == WM_NO_CHANGE |=> $stable(p_lat[0])) else $error("no-change policy broken");
  flag_excl_a:
    assert property (!(fifo_full && fifo_empty)) else $error("queue full and empty together");
  ecc_excl_a:
    assert property (!(ecc_single && ecc_double)) else $error("single and double error together");
  fwft_show_a:
    assert property (fifo_on && fwft && !empty_i && !fv_r && !ctrl_wr && !cfg_bad |=> !fifo_empty) else $error("first word not shown");
  bad_block_a:
    assert property (cfg_bad |-> !p_wgo[0] && !p_wgo[1]) else $error("write with illegal widths");

endmodule // dpr_block_ram

// *** core/dpr_pkg.sv ***
// Shared constants of the dual-port block memory: register offsets,
// control field positions, reset values and width codes.
// Assumes a single clock domain and the plain register port of the top.
package dpr_pkg;

  // Storage geometry of one full block
  localparam int unsigned WORD_W     = 72;
  localparam int unsigned LANE_W     = 9;
  localparam int unsigned LANES      = 8;
  localparam int unsigned BASE_WORDS = 512;
  localparam int unsigned HALF_WORDS = 256;
  localparam int unsigned ADDR_W     = 16;
  localparam int unsigned CNT_W      = 17;

  // Register offsets (byte addresses)
  localparam logic [4:0] OFF_CTRL   = 5'h00;
  localparam logic [4:0] OFF_WIDTH  = 5'h04;
  localparam logic [4:0] OFF_AFULL  = 5'h08;
  localparam logic [4:0] OFF_AEMPTY = 5'h0c;
  localparam logic [4:0] OFF_STATUS = 5'h10;
  localparam logic [4:0] OFF_COUNT  = 5'h14;

  // Control register field positions
  localparam int CB_SPLIT  = 0;
  localparam int CB_SRW    = 1;
  localparam int CB_FIFO   = 2;
  localparam int CB_FWFT   = 3;
  localparam int CB_ECC    = 4;
  localparam int CB_A_OREG = 5;
  localparam int CB_B_OREG = 6;
  localparam int CB_A_WM   = 8;
  localparam int CB_B_WM   = 10;
  localparam int CB_A_HALF = 12;
  localparam int CB_B_HALF = 13;
  localparam int CTRL_W    = 14;

  // Width register field positions
  localparam int WB_A    = 0;
  localparam int WB_B    = 4;
  localparam int WIDTH_W = 7;

  // Width codes: 1, 2, 4, 9, 18, 36, 72 bits
  localparam logic [2:0] WC_1   = 3'h0;
  localparam logic [2:0] WC_4   = 3'h2;
  localparam logic [2:0] WC_9   = 3'h3;
  localparam logic [2:0] WC_18  = 3'h4;
  localparam logic [2:0] WC_36  = 3'h5;
  localparam logic [2:0] WC_72  = 3'h6;
  localparam logic [2:0] WC_BAD = 3'h7;

  // Read-during-write policies
  localparam logic [1:0] WM_READ_FIRST  = 2'h0;
  localparam logic [1:0] WM_WRITE_FIRST = 2'h1;
  localparam logic [1:0] WM_NO_CHANGE   = 2'h2;

  // Values after reset
  localparam logic [CTRL_W-1:0]  CTRL_RST   = 14'h0000;
  localparam logic [WIDTH_W-1:0] WIDTH_RST  = 7'h55;
  localparam logic [CNT_W-1:0]   AFULL_RST  = 17'h001f0;
  localparam logic [CNT_W-1:0]   AEMPTY_RST = 17'h00010;

endpackage

// *** core/dpr_ecc_if.sv ***
// Carrier between the memory top and its SECDED encoder/decoder.
// Purely combinational signals; the user side registers the results.
`timescale 1ns/10ps
interface dpr_ecc_if;
  logic [63:0] enc_data;   // Word to protect
  logic [7:0]  enc_check;  // Generated check bits
  logic [63:0] dec_data;   // Stored or received data
  logic [7:0]  dec_check;  // Stored or received check bits
  logic [63:0] dec_fixed;  // Corrected data
  logic        dec_single; // One bit was repaired
  logic        dec_double; // Uncorrectable error seen

  modport calc (input enc_data, dec_data, dec_check, output enc_check, dec_fixed, dec_single, dec_double);
  modport user (output enc_data, dec_data, dec_check, input enc_check, dec_fixed, dec_single, dec_double);
endinterface

// *** core/dpr_ecc.sv ***
// Hamming SECDED over 64 data bits with 8 check bits.
// Assumes the caller registers outputs; the logic here is combinational.
`timescale 1ns/10ps
module dpr_ecc (
  // Encoder and decoder signals
  dpr_ecc_if.calc e
);

  // Place data at non power-of-two positions 1..71
  function automatic logic [71:0] spread(input logic [63:0] d);
    logic [71:0] c;
    int unsigned j;
    c = '0;
    j = 0;
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p] = d[j];
        j++;
      end
    end
    return c;
  endfunction

  // Position syndrome of a codeword
  function automatic logic [6:0] synd(input logic [71:0] c);
    logic [6:0] s;
    s = '0;
    for (int p = 1; p < 72; p++) begin
      for (int b = 0; b < 7; b++) begin
        if (p[b]) s[b] = s[b] ^ c[p];
      end
    end
    return s;
  endfunction

  // Encoder: seven position checks plus overall parity
  always_comb begin
    logic [71:0] c;
    logic [6:0]  s;
    c = spread(e.enc_data);
    s = synd(c);
    e.enc_check = {^c ^ ^s, s};
  end

  // Decoder: flip the indicated bit, flag a double error
  always_comb begin
    logic [71:0] c;
    logic [6:0]  s;
    logic        odd;
    int unsigned j;
    c = spread(e.dec_data);
    for (int b = 0; b < 7; b++) c[1 << b] = e.dec_check[b];
    s   = synd(c);
    odd = ^c ^ e.dec_check[7];
    j   = 0;
    // Syndrome beyond the last position cannot be a single flip
    if (odd && s != 7'h00 && s < 7'h48) c[s] = ~c[s];
    e.dec_single = odd && s < 7'h48;
    e.dec_double = (!odd && s != 7'h00) || (odd && s >= 7'h48);
    e.dec_fixed  = '0;
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        e.dec_fixed[j] = c[p];
        j++;
      end
    end
  end

endmodule // dpr_ecc

// *** test/dpr_user.sv ***
// User logic model that drives both memory ports and the queue.
// Assumes the block samples its inputs on the rising edge of clk.
`timescale 1ns/10ps
module dpr_user (
  // Clock and queue flags
  input  wire logic        clk,
  input  wire logic        fifo_full,
  input  wire logic        fifo_empty,
  // Port and queue requests
  output logic             a_en,
  output logic [7:0]       a_we,
  output logic [15:0]      a_addr,
  output logic [71:0]      a_din,
  output logic             b_en,
  output logic [7:0]       b_we,
  output logic [15:0]      b_addr,
  output logic [71:0]      b_din,
  output logic             fifo_wr,
  output logic             fifo_rd
);
  // Idle at time zero; port B only reads here
  initial begin
    {a_en, a_we, a_addr, a_din, b_en, b_we, b_addr, b_din, fifo_wr, fifo_rd} = '0;
  end
  // Port A write, or queue push when q is set
  task automatic wr(input logic [15:0] ad, input logic [71:0] d, input logic q);
    logic ok;
    @(posedge clk);
    ok      = !fifo_full; // Flag as left by the previous edge, never stale
    a_en    <= !q;
    a_we    <= q ? 8'h00 : 8'hff;
    fifo_wr <= q & ok;
    a_addr  <= ad;
    a_din   <= d;
    @(posedge clk);
    a_en    <= 1'b0;
    a_we    <= 8'h00;
    fifo_wr <= 1'b0;
    a_din   <= ~d; // Released data must not linger
  endtask
  // Port B read, or queue pop when q is set
  task automatic rd(input logic [15:0] ad, input logic q);
    logic ok;
    @(posedge clk);
    ok      = !fifo_empty; // Flag as left by the previous edge, never stale
    b_en    <= !q;
    fifo_rd <= q & ok;
    b_addr  <= ad;
    @(posedge clk);
    b_en    <= 1'b0;
    fifo_rd <= 1'b0;
  endtask
  // Push that ignores the full flag, to probe the block's refusal
  task automatic wr_blind(input logic [71:0] d);
    @(posedge clk);
    fifo_wr <= 1'b1;
    a_din   <= d;
    @(posedge clk);
    fifo_wr <= 1'b0;
  endtask
endmodule // dpr_user

// *** test/tb_top.sv ***
// Self-checking bench for the dual-port block memory.
// Assumes the user model drives ports; the bench drives registers and codec.
`timescale 1ns/10ps
module tb_top;
  import dpr_pkg::*;
  logic        clk, resetn, reg_wr, reg_rd, fifo_full, fifo_empty, fifo_afull, fifo_aempty;
  logic        a_en, b_en, fifo_wr, fifo_rd, ecc_single, ecc_double, ext_single, ext_double;
  logic [7:0]  a_we, b_we, ext_check, c;
  logic [15:0] a_addr, b_addr;
  logic [71:0] a_din, b_din, a_dout, b_dout, ext_code, d;
  logic [71:0] dd [8];   // Words written in the random pass
  logic [63:0] ext_data, ext_fixed;
  logic [4:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, q;
  int          seed, i, num_errors, checks;
  dpr_block_ram #(.CASCADE(0)) DUT (.clk, .resetn, .a_en, .a_we, .a_addr, .a_din, .a_dout,
    .b_en, .b_we, .b_addr, .b_din, .b_dout, .fifo_wr, .fifo_rd, .fifo_full, .fifo_empty,
    .fifo_afull, .fifo_aempty, .ecc_single, .ecc_double, .ext_data, .ext_check, .ext_code,
    .ext_fixed, .ext_single, .ext_double, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  dpr_user u (.clk, .fifo_full, .fifo_empty, .a_en, .a_we, .a_addr, .a_din, .b_en, .b_we,
    .b_addr, .b_din, .fifo_wr, .fifo_rd);
  // Free-running 8 ns clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // 36-bit element in the low bits, upper zero
  function automatic logic [71:0] m36(input logic [71:0] x);
    return {36'h0, x[35:0]};
  endfunction
  // Stored layout of a protected word: each lane is a check bit over a data byte
  function automatic logic [71:0] pk(input logic [63:0] x, input logic [7:0] k);
    logic [71:0] r;
    for (int j = 0; j < 8; j++) r[j * 9 +: 9] = {k[j], x[j * 8 +: 8]};
    return r;
  endfunction
  // Compare and count
  task automatic chk(input string n, input logic [71:0] e, input logic [71:0] s);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // One register cycle; read data taken in the cycle after
  task automatic rw(input logic w, input logic [4:0] ad, input logic [31:0] wd);
    @(posedge clk);
    reg_wr    <= w;
    reg_rd    <= !w;
    reg_addr  <= ad;
    reg_wdata <= wd;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  // Verdict, reached from the main sequence or the watchdog
  task automatic final_report;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog well beyond the roughly 1,130 cycles needed
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    final_report();
  end
  // Main sequence
  initial begin
    seed = 54428;
    {resetn, reg_wr, reg_rd, reg_addr, reg_wdata, ext_data, ext_code} = '0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    rw(0, OFF_WIDTH, 0); chk("width", 72'(WIDTH_RST), 72'(q));
    rw(0, OFF_AFULL, 0); chk("afull_lvl", 72'(AFULL_RST), 72'(q));
    rw(0, OFF_STATUS, 0); chk("status", 72'h0a, 72'(q));
    rw(0, 5'h1c, 0); chk("unmapped", 72'h0, 72'(q));
    // Random words written on A, read back on B
    for (i = 0; i < 8; i++) begin
      dd[i] = 72'({$random(seed), $random(seed), $random(seed)});
      u.wr(16'(i), dd[i], 1'b0);
      u.rd(16'(i), 1'b0);
      #1 chk("b_dout", m36(dd[i]), b_dout);
    end
    // Output stage on B: old word for one more cycle
    rw(1, OFF_CTRL, 32'h40);
    u.rd(16'h0, 1'b0);
    #1 chk("b_oreg_early", m36(dd[7]), b_dout);
    @(posedge clk);
    #1 chk("b_oreg", m36(dd[0]), b_dout);
    // Port A writes under each policy: old, new, then unchanged element
    u.wr(16'h0, dd[6], 1'b0);
    #1 chk("a_old", m36(dd[0]), a_dout);
    rw(1, OFF_CTRL, 32'h140);
    u.wr(16'h0, dd[1], 1'b0);
    #1 chk("a_new", m36(dd[1]), a_dout);
    rw(1, OFF_CTRL, 32'h240);
    u.wr(16'h0, dd[2], 1'b0);
    #1 chk("a_kept", m36(dd[1]), a_dout);
    // Codec: one flipped bit repaired, two reported
    d = dd[3];
    @(posedge clk);
    ext_data <= d[63:0];
    @(posedge clk);
    #1 c = ext_check;
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      ext_code <= {c, d[63:0] ^ (i ? 64'h28 : 64'h8)};
      @(posedge clk);
      #1 chk("ext_single", 72'(i == 0), 72'(ext_single));
      chk("ext_double", 72'(i == 1), 72'(ext_double));
      if (i == 0) chk("ext_fixed", 72'(d[63:0]), 72'(ext_fixed));
    end
    // Standard queue: order kept, empty after draining
    rw(1, OFF_AFULL, 32'h2);
    rw(1, OFF_AEMPTY, 32'h1);
    rw(1, OFF_CTRL, 32'h04);
    for (i = 0; i < 3; i++) u.wr(16'h0, dd[i], 1'b1);
    #1 chk("q_empty", 72'h0, 72'(fifo_empty));
    chk("q_afull", 72'h1, 72'(fifo_afull));
    chk("q_aempty", 72'h0, 72'(fifo_aempty));
    for (i = 0; i < 3; i++) begin
      u.rd(16'h0, 1'b1);
      #1 chk("q_data", m36(dd[i]), b_dout);
    end
    chk("q_drained", 72'h1, 72'(fifo_empty));
    chk("q_aempty_end", 72'h1, 72'(fifo_aempty));
    // Fall-through: first word shown before any read
    rw(1, OFF_CTRL, 32'h0c);
    u.wr(16'h0, dd[5], 1'b1);
    repeat (2) @(posedge clk);
    #1 chk("fwft_data", m36(dd[5]), b_dout);
    u.rd(16'h0, 1'b1);
    #1 chk("fwft_empty", 72'h1, 72'(fifo_empty));
    // Full queue of whole words; one more push must be refused
    rw(1, OFF_WIDTH, 32'h06);
    rw(1, OFF_CTRL, 32'h04);
    for (i = 0; i < BASE_WORDS; i++) u.wr(16'h0, 72'(i), 1'b1);
    u.wr_blind(72'h0);
    #1 chk("q_full", 72'h1, 72'(fifo_full));
    rw(0, OFF_COUNT, 0); chk("q_count", 72'(BASE_WORDS), 72'(q));
    // Protected word with one stored bit flipped: repaired and reported
    rw(1, OFF_WIDTH, 32'h66);
    rw(1, OFF_CTRL, 32'h02);
    u.wr(16'h8, pk(d[63:0] ^ 64'h1, c), 1'b0);
    rw(1, OFF_CTRL, 32'h12);
    u.rd(16'h8, 1'b0);
    #1 chk("ecc_fixed", 72'(d[63:0]), 72'(b_dout[63:0]));
    chk("ecc_single", 72'h1, 72'(ecc_single));
    chk("ecc_double", 72'h0, 72'(ecc_double));
    final_report();
  end
endmodule // tb_top
